// File: rtl/adcisp_pkg.sv
// Purpose: shared constants and types of the adc serial register port
// Assumes: clk at 20 MHz, synchronous active-high reset
// Notes: what this block does and the constants used by the sync, top, check and bench files
package adcisp_pkg;
  // clock and bus timing
  localparam int CLK_HZ = 20_000_000;
  localparam int FM_KBPS = 400;
  localparam int CYC_PER_BIT_FM = CLK_HZ / (FM_KBPS * 1000);
  localparam int MIN_CYC_PER_BIT = 8;
  localparam int TIMEOUT_MS = 25;
  localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
  // register pointer values
  localparam logic [7:0] PTR_RESULT = 8'h00;
  localparam logic [7:0] PTR_SETUP = 8'h01;
  // reset values
  localparam logic [15:0] RESULT_RST = 16'h0000;
  localparam logic [15:0] SETUP_RST = 16'h8583;
  // slave addresses and general-call reset command
  localparam logic [6:0] ADDR_GND = 7'h48;
  localparam logic [6:0] ADDR_VDD = 7'h49;
  localparam logic [6:0] ADDR_SCL = 7'h4b;
  localparam logic [6:0] ADDR_GCALL = 7'h00;
  localparam logic [7:0] GC_RESET_CMD = 8'h06;
  // setup field positions
  localparam int OS_BIT = 15;
  localparam int SEL_LSB = 12;
  localparam int GAIN_LSB = 9;
  localparam int MODE_BIT = 8;
  localparam int RATE_LSB = 5;
  localparam int LOW_W = 5;
  // result format
  localparam int RES_LSB = 4;
  localparam logic signed [15:0] RES_MAX = 16'sh07ff;
  localparam logic signed [15:0] RES_MIN = -16'sh0800;
  localparam logic [11:0] RES_POS_FS = 12'h7ff;
  localparam logic [11:0] RES_NEG_FS = 12'h800;
  // synchroniser lanes
  localparam int SYN_N = 3;
  localparam int SYN_SCL = 0;
  localparam int SYN_SDA = 1;
  localparam int SYN_STRAP = 2;
  localparam logic [SYN_N-1:0] SYN_IDLE = 3'h3;
  // serial engine states
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK_OUT, ST_RX, ST_TX, ST_ACK_IN} adcisp_state_t;
endpackage

// File: rtl/adcisp_pins_if.sv
// Purpose: carries synchronised pin levels between sync stage and port logic
// Assumes: one clock domain
// Notes: cur is the settled sample, prev the one before it
`timescale 1ns/10ps
interface adcisp_pins_if #(parameter int N = 3);
  logic [N-1:0] cur;
  logic [N-1:0] prev;
  modport src (output cur, output prev);
  modport dst (input cur, input prev);
endinterface

// File: rtl/adcisp_sync.sv
// Purpose: two-flop synchroniser plus history stage for the bus pins
// Assumes: inputs asynchronous to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/10ps
module adcisp_sync #(
  parameter int N = adcisp_pkg::SYN_N,
  parameter logic [N-1:0] IDLE_VAL = adcisp_pkg::SYN_IDLE
) (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // raw pins
  input wire logic [N-1:0] raw,
  // synchronised levels
  adcisp_pins_if.src pins
);
  logic [N-1:0] meta_q;
  logic [N-1:0] cur_q;
  logic [N-1:0] prev_q;

  // one chain per lane; bus lines idle high
  for (genvar i = 0; i < N; i++) begin : g_lane
    always_ff @(posedge clk) begin
      if (rst) begin
        meta_q[i] <= IDLE_VAL[i];
        cur_q[i] <= IDLE_VAL[i];
        prev_q[i] <= IDLE_VAL[i];
      end else if (ce) begin
        meta_q[i] <= raw[i];
        cur_q[i] <= meta_q[i];
        prev_q[i] <= cur_q[i];
      end
    end
  end

  assign pins.cur = cur_q;
  assign pins.prev = prev_q;
endmodule

// File: rtl/adcisp_top.sv
// Purpose: serial slave register port of a small monitoring adc
// Assumes: clk 20 MHz, bus clock from the master, pins open drain
// Notes: conversion engine sits outside; it sees setup fields and start pulse
`timescale 1ns/10ps
module adcisp_top #(
  parameter int TIMEOUT_CYCLES = adcisp_pkg::TIMEOUT_CYC
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // address strap pin
  input wire logic addr_strap_in,
  // conversion engine side
  input wire logic result_valid,
  input wire logic signed [15:0] result_raw,
  output logic conv_start,
  output logic conv_busy,
  output logic [2:0] input_select,
  output logic [2:0] gain_range_select,
  output logic single_shot_mode,
  output logic [2:0] sample_rate_select,
  output logic [4:0] setup_low_bits,
  output logic bus_busy
);
  localparam int TW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYCLES - 1);

  // refuse settings the sampler or counter cannot serve
  if (TIMEOUT_CYCLES < 2) begin : g_chk_tmo
    $error("timeout count too small");
  end
  if (adcisp_pkg::CYC_PER_BIT_FM < adcisp_pkg::MIN_CYC_PER_BIT) begin : g_chk_rate
    $error("clock too slow for fast-mode sampling");
  end

  adcisp_pins_if #(.N(adcisp_pkg::SYN_N)) pins ();

  // bus and strap pins pass two flops before use
  adcisp_sync #(.N(adcisp_pkg::SYN_N), .IDLE_VAL(adcisp_pkg::SYN_IDLE)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .raw({addr_strap_in, sda_in, scl_in}),
    .pins(pins.src)
  );

  adcisp_pkg::adcisp_state_t st_q;
  logic [3:0] bit_cnt_q;
  logic [1:0] byte_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] lo_hold_q;
  logic half_q;
  logic rw_q;
  logic gc_q;
  logic ack_q;
  logic oe_n_q;
  logic [6:0] own_addr_q;
  logic strap_hi_q;
  logic ptr_setup_q;
  logic [14:0] setup_q;
  logic [15:0] result_q;
  logic [7:0] wr_hi_q;
  logic busy_q;
  logic start_q;
  logic bus_busy_q;
  logic [TW-1:0] tmo_cnt_q;

  logic scl_c;
  logic scl_p;
  logic sda_c;
  logic sda_p;
  logic strap_c;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic tmo_ev;
  logic addr_hit;
  logic gc_hit;
  logic wr_ev;
  logic gc_rst_ev;
  logic start_req;
  logic [15:0] live_word;
  logic [7:0] rd_byte;
  logic [14:0] new_setup;

  // synchronised levels and their edges
  assign scl_c = pins.cur[adcisp_pkg::SYN_SCL];
  assign scl_p = pins.prev[adcisp_pkg::SYN_SCL];
  assign sda_c = pins.cur[adcisp_pkg::SYN_SDA];
  assign sda_p = pins.prev[adcisp_pkg::SYN_SDA];
  assign strap_c = pins.cur[adcisp_pkg::SYN_STRAP];
  assign scl_rise = ce && scl_c && !scl_p;
  assign scl_fall = ce && !scl_c && scl_p;

  // bus conditions need the clock high on both samples
  assign start_ev = ce && scl_c && scl_p && !sda_c && sda_p;
  assign stop_ev = ce && scl_c && scl_p && sda_c && !sda_p;
  assign tmo_ev = ce && (st_q != adcisp_pkg::ST_IDLE) && (tmo_cnt_q == TMO_LAST);

  // address decode after the direction bit has arrived
  assign addr_hit = (shift_q[7:1] == own_addr_q);
  assign gc_hit = (shift_q[7:1] == adcisp_pkg::ADDR_GCALL) && !shift_q[0];

  // a received data byte completes on the eighth falling clock
  assign wr_ev = (st_q == adcisp_pkg::ST_RX) && scl_fall && (bit_cnt_q == 4'h8);
  assign gc_rst_ev = wr_ev && gc_q && (byte_cnt_q == 2'h0) && (shift_q == adcisp_pkg::GC_RESET_CMD);

  // read view; start flag reads high when idle
  assign live_word = ptr_setup_q ? {!busy_q, setup_q} : result_q;
  // low byte is held from the high-byte load so the pair is coherent
  assign rd_byte = half_q ? lo_hold_q : live_word[15:8];

  // single-shot start only from the power-down state
  assign new_setup = {wr_hi_q[6:0], shift_q};
  assign start_req = wr_ev && !gc_q && (byte_cnt_q == 2'h2) && ptr_setup_q &&
                     wr_hi_q[7] && new_setup[adcisp_pkg::MODE_BIT] && !busy_q;

  // result saturation into 12 bits
  function automatic logic [11:0] adcisp_sat(input logic signed [15:0] v);
    logic [11:0] r;
    r = v[11:0];
    if (v > adcisp_pkg::RES_MAX) begin
      r = adcisp_pkg::RES_POS_FS;
    end else if (v < adcisp_pkg::RES_MIN) begin
      r = adcisp_pkg::RES_NEG_FS;
    end
    return r;
  endfunction

  // serial engine: sample on rising clock, change data on falling clock
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= adcisp_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      byte_cnt_q <= 2'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      lo_hold_q <= 8'h00;
      half_q <= 1'b0;
      rw_q <= 1'b0;
      gc_q <= 1'b0;
      ack_q <= 1'b0;
      oe_n_q <= 1'b1;
    end else if (ce) begin
      if (tmo_ev || stop_ev) begin
        st_q <= adcisp_pkg::ST_IDLE;
        oe_n_q <= 1'b1;
      end else if (start_ev) begin
        // repeated start lands here too
        st_q <= adcisp_pkg::ST_ADDR;
        bit_cnt_q <= 4'h0;
        byte_cnt_q <= 2'h0;
        half_q <= 1'b0;
        oe_n_q <= 1'b1;
      end else begin
        unique case (st_q)
          adcisp_pkg::ST_IDLE: begin
            oe_n_q <= 1'b1;
          end
          adcisp_pkg::ST_ADDR: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_c};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (scl_fall && (bit_cnt_q == 4'h8)) begin
              if (addr_hit || gc_hit) begin
                st_q <= adcisp_pkg::ST_ACK_OUT;
                oe_n_q <= 1'b0;
                rw_q <= shift_q[0] && addr_hit;
                gc_q <= !addr_hit;
              end else begin
                // not ours: leave data released until the next start
                st_q <= adcisp_pkg::ST_IDLE;
              end
            end
          end
          adcisp_pkg::ST_ACK_OUT: begin
            if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (rw_q) begin
                tx_q <= rd_byte;
                oe_n_q <= rd_byte[7];
                half_q <= !half_q;
                if (!half_q) begin
                  lo_hold_q <= live_word[7:0];
                end
                st_q <= adcisp_pkg::ST_TX;
              end else begin
                oe_n_q <= 1'b1;
                st_q <= adcisp_pkg::ST_RX;
              end
            end
          end
          adcisp_pkg::ST_RX: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_c};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else if (wr_ev) begin
              st_q <= adcisp_pkg::ST_ACK_OUT;
              oe_n_q <= 1'b0;
              if (byte_cnt_q != 2'h3) begin
                byte_cnt_q <= byte_cnt_q + 2'h1;
              end
            end
          end
          adcisp_pkg::ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_q == 4'h7) begin
                oe_n_q <= 1'b1;
                st_q <= adcisp_pkg::ST_ACK_IN;
              end else begin
                tx_q <= {tx_q[6:0], 1'b0};
                oe_n_q <= tx_q[6];
                bit_cnt_q <= bit_cnt_q + 4'h1;
              end
            end
          end
          adcisp_pkg::ST_ACK_IN: begin
            if (scl_rise) begin
              ack_q <= !sda_c;
            end else if (scl_fall) begin
              bit_cnt_q <= 4'h0;
              if (ack_q) begin
                tx_q <= rd_byte;
                oe_n_q <= rd_byte[7];
                half_q <= !half_q;
                if (!half_q) begin
                  lo_hold_q <= live_word[7:0];
                end
                st_q <= adcisp_pkg::ST_TX;
              end else begin
                st_q <= adcisp_pkg::ST_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

  // strap level at start, then again once the clock first goes low
  always_ff @(posedge clk) begin
    if (rst) begin
      strap_hi_q <= 1'b0;
      own_addr_q <= adcisp_pkg::ADDR_GND;
    end else if (ce) begin
      if (start_ev) begin
        strap_hi_q <= strap_c;
      end else if ((st_q == adcisp_pkg::ST_ADDR) && scl_fall && (bit_cnt_q == 4'h0)) begin
        // a strap that follows the clock reads low here but high at start
        if (!strap_hi_q) begin
          own_addr_q <= adcisp_pkg::ADDR_GND;
        end else if (strap_c) begin
          own_addr_q <= adcisp_pkg::ADDR_VDD;
        end else begin
          own_addr_q <= adcisp_pkg::ADDR_SCL;
        end
      end
    end
  end

  // register file, pointer, start flag and result capture
  always_ff @(posedge clk) begin
    if (rst || (ce && gc_rst_ev)) begin
      ptr_setup_q <= 1'b0;
      setup_q <= adcisp_pkg::SETUP_RST[14:0];
      result_q <= adcisp_pkg::RESULT_RST;
      wr_hi_q <= 8'h00;
      busy_q <= 1'b0;
      start_q <= 1'b0;
    end else if (ce) begin
      start_q <= start_req;
      if (wr_ev && !gc_q) begin
        unique case (byte_cnt_q)
          2'h0: ptr_setup_q <= (shift_q == adcisp_pkg::PTR_SETUP);
          2'h1: wr_hi_q <= shift_q;
          2'h2: begin
            if (ptr_setup_q) begin
              setup_q <= new_setup;
            end
          end
          2'h3: begin
            // extra bytes are acknowledged and dropped
          end
        endcase
      end
      // a start in the same cycle as a finished result wins
      if (start_req) begin
        busy_q <= 1'b1;
      end else if (result_valid) begin
        busy_q <= 1'b0;
      end
      if (result_valid) begin
        result_q <= {adcisp_sat(result_raw), 4'h0};
      end
    end
  end

  // idle watchdog, restarted by every clock edge of the bus
  always_ff @(posedge clk) begin
    if (rst) begin
      tmo_cnt_q <= '0;
    end else if (ce) begin
      if ((st_q == adcisp_pkg::ST_IDLE) || scl_rise || scl_fall || start_ev) begin
        tmo_cnt_q <= '0;
      end else if (!tmo_ev) begin
        tmo_cnt_q <= tmo_cnt_q + TW'(1);
      end
    end
  end

  // busy between start and stop; timeout also frees it
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_busy_q <= 1'b0;
    end else if (ce) begin
      if (stop_ev || tmo_ev) begin
        bus_busy_q <= 1'b0;
      end else if (start_ev) begin
        bus_busy_q <= 1'b1;
      end
    end
  end

  // open drain: only ever pull low, never touch the clock line
  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_q;
  assign conv_start = start_q;
  assign conv_busy = busy_q;
  assign input_select = setup_q[adcisp_pkg::SEL_LSB +: 3];
  assign gain_range_select = setup_q[adcisp_pkg::GAIN_LSB +: 3];
  assign single_shot_mode = setup_q[adcisp_pkg::MODE_BIT];
  assign sample_rate_select = setup_q[adcisp_pkg::RATE_LSB +: 3];
  assign setup_low_bits = setup_q[adcisp_pkg::LOW_W-1:0];
  assign bus_busy = bus_busy_q;
endmodule

// File: verif/adcisp_top_asserts.sv
// Purpose: concurrent checks on the port pins of adcisp_top
// Assumes: single clk domain, sync active-high reset
// Notes: bus edges seen raw here, design sees them ~3 clk later
`timescale 1ns/10ps
module adcisp_top_asserts #(
  parameter int TIMEOUT_CYCLES = adcisp_pkg::TIMEOUT_CYC
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic addr_strap_in,
  // conversion engine side
  input wire logic result_valid,
  input wire logic signed [15:0] result_raw,
  input wire logic conv_start,
  input wire logic conv_busy,
  input wire logic [2:0] input_select,
  input wire logic [2:0] gain_range_select,
  input wire logic single_shot_mode,
  input wire logic [2:0] sample_rate_select,
  input wire logic [4:0] setup_low_bits,
  input wire logic bus_busy
);
  logic scl_q;
  int idle_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // previous clock-line level
  always_ff @(posedge clk) begin
    scl_q <= scl_in;
  end
  // quiet cycles in an open transaction; slack covers sync lag
  always_ff @(posedge clk) begin
    if (rst || !bus_busy || scl_in != scl_q) begin
      idle_q <= 0;
    end else begin
      idle_q <= idle_q + 1;
    end
  end
  chk_reset_vals: assert property ($fell(rst) |-> sda_oe_n && !bus_busy && !conv_busy && !conv_start
    && {input_select, gain_range_select, single_shot_mode, sample_rate_select, setup_low_bits}
    == adcisp_pkg::SETUP_RST[14:0]) else $error("reset state wrong");
  chk_pull_clk_low: assert property ($fell(sda_oe_n) |-> !scl_in && bus_busy)
    else $error("data pulled low outside clock low phase");
  chk_hold_clk_high: assert property ($rose(scl_in) |=> $stable(sda_oe_n) [*8])
    else $error("data moved while clock high");
  chk_start_busy: assert property (scl_in && $past(scl_in) && $fell(sda_in) |-> ##[1:6] bus_busy)
    else $error("start not seen");
  chk_stop_free: assert property (scl_in && $past(scl_in) && $rose(sda_in) |-> ##[1:6] !bus_busy)
    else $error("stop not seen");
  chk_idle_limit: assert property (idle_q <= TIMEOUT_CYCLES + 8)
    else $error("idle bus not timed out");
  chk_start_pulse: assert property (conv_start |=> !conv_start && conv_busy && single_shot_mode)
    else $error("start pulse wrong");
  chk_done_clears: assert property (result_valid |=> !conv_busy || conv_start)
    else $error("busy not cleared");
  chk_busy_no_start: assert property (conv_busy && !result_valid |=> !conv_start)
    else $error("start while busy");
endmodule

bind adcisp_top adcisp_top_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
  .clk(clk), .rst(rst), .ce(ce), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .addr_strap_in(addr_strap_in), .result_valid(result_valid),
  .result_raw(result_raw), .conv_start(conv_start), .conv_busy(conv_busy),
  .input_select(input_select), .gain_range_select(gain_range_select),
  .single_shot_mode(single_shot_mode), .sample_rate_select(sample_rate_select),
  .setup_low_bits(setup_low_bits), .bus_busy(bus_busy)
);

// File: verif/adcisp_master_model.sv
// Purpose: behavioural bus master for the serial register port
// Assumes: open-drain wire resolved by the bench, pull-up when released
// Notes: clock only runs inside frames and idles high
`timescale 1ns/10ps
module adcisp_master_model #(
  // half bit time; 2.6 us bits stay under the fast-mode limit and every quarter lands on a clk fall
  parameter int HALF_NS = 1300
) (
  // lines driven by the master
  output logic scl,
  output logic sda_rel,
  // resolved data wire
  input wire logic sda
);
  // idle bus sits high
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // one pulse: data set mid low phase, sampled mid high phase
  task automatic clk_bit(input logic b, output logic r);
    #(HALF_NS/2) sda_rel = b;
    #(HALF_NS/2) scl = 1'b1;
    #(HALF_NS/2) r = sda;
    #(HALF_NS/2) scl = 1'b0;
  endtask
  // also serves as repeated start from a low clock
  task automatic start();
    sda_rel = 1'b1;
    #(HALF_NS/2) scl = 1'b1;
    #(HALF_NS) sda_rel = 1'b0;
    #(HALF_NS) scl = 1'b0;
  endtask
  task automatic stop();
    #(HALF_NS/2) sda_rel = 1'b0;
    #(HALF_NS/2) scl = 1'b1;
    #(HALF_NS) sda_rel = 1'b1;
    #(HALF_NS);
  endtask
  // byte out msb first, then release for the ack bit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = !r;
  endtask
  // byte in; last=1 ends the read with a not-acknowledge
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      d[i] = r;
    end
    clk_bit(last, r);
  endtask
endmodule

// File: verif/adc_i2c_slave_register_port_bench.sv
// Purpose: self-checking bench for adcisp_top through its serial bus
// Assumes: short idle timeout parameter, ce held high
// Notes: master model runs on its own delays, unrelated to clk
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module adc_i2c_slave_register_port_bench;
  localparam int TO = 2000;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic result_valid = 1'b0;
  logic signed [15:0] result_raw = 16'sh0000;
  logic [1:0] strap_mode = 2'h0;
  logic scl, sda_rel, sda_out, sda_oe_n, conv_start, conv_busy, single_shot_mode, bus_busy;
  logic [2:0] input_select, gain_range_select, sample_rate_select;
  logic [4:0] setup_low_bits;
  logic [14:0] fields;
  wire sda_wire;
  wire addr_strap;
  int num_errors = 0;
  int checks_done = 0;
  logic [6:0] dev = adcisp_pkg::ADDR_GND;
  logic [15:0] v;
  logic a;
  logic [6:0] addr_tab [3] = '{adcisp_pkg::ADDR_GND, adcisp_pkg::ADDR_VDD, adcisp_pkg::ADDR_SCL};
  logic signed [15:0] raw_tab [6] = '{16'sh07ff, -16'sh0800, 16'sh1388, -16'sh0bb8, 16'sh0001, -16'sh0001};
  logic [15:0] res_tab [6] = '{16'h7ff0, 16'h8000, 16'h7ff0, 16'h8000, 16'h0010, 16'hfff0};

  always #25 clk = ~clk;
  // open drain wire with pull-up; strap may follow the clock line
  assign sda_wire = sda_rel & (sda_oe_n | sda_out);
  assign addr_strap = strap_mode[1] ? scl : strap_mode[0];
  assign fields = {input_select, gain_range_select, single_shot_mode, sample_rate_select, setup_low_bits};

  adcisp_top #(.TIMEOUT_CYCLES(TO)) uut (
    .clk(clk), .rst(rst), .ce(1'b1), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .addr_strap_in(addr_strap), .result_valid(result_valid),
    .result_raw(result_raw), .conv_start(conv_start), .conv_busy(conv_busy),
    .input_select(input_select), .gain_range_select(gain_range_select),
    .single_shot_mode(single_shot_mode), .sample_rate_select(sample_rate_select),
    .setup_low_bits(setup_low_bits), .bus_busy(bus_busy)
  );
  adcisp_master_model m (.scl(scl), .sda_rel(sda_rel), .sda(sda_wire));

  // pointer write plus nb content bytes
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d, input int nb);
    m.start();
    m.wbyte({dev, 1'b0}, a);
    `CHK(a, 1'b1)
    m.wbyte(ptr, a);
    `CHK(a, 1'b1)
    if (nb > 0) m.wbyte(d[15:8], a);
    if (nb > 1) m.wbyte(d[7:0], a);
    `CHK(a, 1'b1)
    m.stop();
  endtask
  // register read; nack1 stops after the high byte
  task automatic rd(input logic nack1);
    m.start();
    m.wbyte({dev, 1'b1}, a);
    m.rbyte(nack1, v[15:8]);
    v[7:0] = 8'h00;
    if (!nack1) m.rbyte(1'b1, v[7:0]);
    m.stop();
  endtask
  task automatic put_result(input logic signed [15:0] r);
    @(negedge clk);
    result_valid = 1'b1;
    result_raw = r;
    @(negedge clk);
    result_valid = 1'b0;
  endtask
  task final_report;
    $display("mismatches %0d, comparisons %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // watchdog well past the expected ~2.2 ms of traffic
  initial begin
    #4000000;
    num_errors++;
    final_report();
  end

  initial begin
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    rd(1'b0);
    `CHK(v, adcisp_pkg::RESULT_RST)
    `CHK(fields, adcisp_pkg::SETUP_RST[14:0])
    wr(adcisp_pkg::PTR_SETUP, 16'h0000, 0);
    rd(1'b0);
    `CHK(v, adcisp_pkg::SETUP_RST)
    rd(1'b0);
    `CHK(v, adcisp_pkg::SETUP_RST)
    // each strap wiring: neighbour address refused, own one taken
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      strap_mode = i[1:0];
      dev = addr_tab[i];
      m.start();
      m.wbyte({dev ^ 7'h01, 1'b0}, a);
      `CHK(a, 1'b0)
      m.start();
      m.wbyte({dev, 1'b0}, a);
      `CHK(a, 1'b1)
      m.stop();
    end
    @(negedge clk);
    strap_mode = 2'h0;
    dev = adcisp_pkg::ADDR_GND;
    // full write, then a write cut after the high byte
    wr(adcisp_pkg::PTR_SETUP, 16'h4443, 2);
    `CHK(fields, 15'h4443)
    rd(1'b0);
    `CHK(v, 16'hc443)
    wr(adcisp_pkg::PTR_SETUP, 16'h1234, 1);
    rd(1'b0);
    `CHK(v, 16'hc443)
    // single-shot start: status bit reads busy
    wr(adcisp_pkg::PTR_SETUP, 16'h8583, 2);
    `CHK(conv_busy, 1'b1)
    rd(1'b0);
    `CHK(v, 16'h0583)
    // a second start while busy is ignored, busy holds
    wr(adcisp_pkg::PTR_SETUP, 16'h8583, 2);
    `CHK(conv_busy, 1'b1)
    wr(adcisp_pkg::PTR_RESULT, 16'h0000, 0);
    put_result(16'sh0123);
    `CHK(conv_busy, 1'b0)
    rd(1'b1);
    `CHK(v, 16'h1200)
    for (int k = 0; k < 6; k++) begin
      put_result(raw_tab[k]);
      rd(1'b0);
      if (k < 2) `CHK(v, res_tab[k])
      else `CHK(v, res_tab[k])
    end
    // general call: read refused, reset command restores defaults
    // start bit with continuous mode must not start a conversion
    wr(adcisp_pkg::PTR_SETUP, 16'hc443, 2);
    `CHK(conv_busy, 1'b0)
    `CHK(fields, 15'h4443)
    dev = adcisp_pkg::ADDR_GCALL;
    m.start();
    m.wbyte({dev, 1'b1}, a);
    `CHK(a, 1'b0)
    m.start();
    m.wbyte({dev, 1'b0}, a);
    `CHK(a, 1'b1)
    m.wbyte(adcisp_pkg::GC_RESET_CMD, a);
    `CHK(a, 1'b1)
    m.stop();
    `CHK(fields, adcisp_pkg::SETUP_RST[14:0])
    dev = adcisp_pkg::ADDR_GND;
    rd(1'b0);
    `CHK(v, adcisp_pkg::RESULT_RST)
    // master stalls mid-frame, then starts afresh
    m.start();
    m.wbyte({dev, 1'b0}, a);
    repeat (TO + 200) @(negedge clk);
    `CHK(bus_busy, 1'b0)
    `CHK(sda_oe_n, 1'b1)
    wr(adcisp_pkg::PTR_SETUP, 16'h0000, 0);
    rd(1'b0);
    `CHK(v, adcisp_pkg::SETUP_RST)
    final_report();
  end
endmodule
